// ===== inc/dac_update_defines.svh
`ifndef DAC_UPDATE_DEFINES_SVH
`define DAC_UPDATE_DEFINES_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define FRAME_BITS         5'd24
`define CMD_MSB            23
`define CMD_LSB            20
`define ADDR_MSB           19
`define ADDR_LSB           16
`define CODE_MSB           15
`define CODE_LSB           0
`define MASK_MSB           7
`define GAIN_FIELD_MSB     2
`define GAIN_BIT           2

// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_WRITE_INPUT    4'h1
`define CMD_UPDATE_DAC     4'h2
`define CMD_WRITE_UPDATE   4'h3
`define CMD_LOAD_MASK      4'h5
`define CMD_SOFT_RESET     4'h6
`define CMD_GAIN_SETUP     4'h7

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define NUM_CHANNELS       8
`define MASK_RESET         8'h00
`define GAIN_RESET         3'h0
`define ZERO_SCALE_CODE    16'h0000
`define MID_SCALE_CODE     16'h8000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS      10
`define POR_TIME_NS        500
`define POR_CYCLES         ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== inc/dac_update_pkg.sv
package dac_update_pkg;

    typedef enum logic [1:0] {
        PWR_POR,
        PWR_HW_RESET,
        PWR_RUN
    } power_state_e;

    typedef logic [15:0] code_t;
    typedef logic [3:0]  cmd_t;
    typedef logic [3:0]  addr_t;

endpackage

// ===== design/dac_channel_cell.sv
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module dac_channel_cell (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 clear,
    input  wire dac_update_pkg::code_t clear_code,
    input  wire logic                 write_input,
    input  wire logic                 write_dac,
    input  wire logic                 copy_input,
    input  wire dac_update_pkg::code_t data,
    output dac_update_pkg::code_t     input_code,
    output dac_update_pkg::code_t     dac_code
);

    // ----------------------------------------
    // input register
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_code <= `ZERO_SCALE_CODE;
        end else if (clear) begin
            input_code <= clear_code;
        end else if (write_input) begin
            input_code <= data;
        end
    end

    // ----------------------------------------
    // dac register, holds until loaded
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dac_code <= `ZERO_SCALE_CODE;
        end else if (clear) begin
            dac_code <= clear_code;
        end else if (write_dac) begin
            dac_code <= data;
        end else if (copy_input) begin
            dac_code <= input_code;
        end
    end

endmodule

// ===== design/dac_update_reset_gain_control.sv
// Overview of operation
// [RULE1] strobe low in write: input and dac
// [RULE2] strobe high: input only, later edge
// [RULE3] command 0101 loads eight-bit channel mask
// [RULE4] mask resets to zero, pin controls
// [RULE5] masked channel sees strobe as high
// [RULE6] strobe falling edge copies unmasked channels
// [RULE7] strobe held low overrides the mask
// [RULE8] command 0010 copies input to dac
// [RULE9] command 0011 writes input and dac
// [RULE10] reset pin clears to selected level
// [RULE11] cleared code held until rewritten
// [RULE12] reset pin low blocks every update; mask and gain commands still load while it is low
// [RULE13] command 0110 repeats the power-on reset
// [RULE14] pins ignored during power-on reset
// [RULE15] power-up level from reset level select
// [RULE16] power-up level held until written
// [RULE17] gain bit two selects gain two
// [RULE18] host sends gain frame, reserved zero
// [RULE19] exactly 24 bits, act on sync rise
// [RULE20] strobe low makes input transparent
// [RULE21] update command drives outputs directly
// [RULE22] bits 19:16 address, 15:0 code
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module dac_update_reset_gain_control (
    input  wire logic  CLK,
    input  wire logic  RESETN,
    input  wire logic  SCLK,
    input  wire logic  SYNC_N,
    input  wire logic  SDI,
    input  wire logic  LOAD_STROBE_N,
    input  wire logic  DAC_RESET_N,
    input  wire logic  RESET_LEVEL_SELECT,
    output logic [127:0] DAC_CODES,
    output logic [7:0]   STROBE_MASK,
    output logic         GAIN_SEL,
    output logic         POR_BUSY
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam int NCH = `NUM_CHANNELS;

    logic                        rst_meta_reg;
    logic                        rst_sync_reg;
    logic                        rst_n;
    logic [4:0]                  pin_meta_reg;
    logic [4:0]                  pin_sync_reg;
    logic [2:0]                  pin_prev_reg;
    logic                        sclk_s;
    logic                        sync_n_s;
    logic                        sdi_s;
    logic                        strobe_n_s;
    logic                        hw_reset_n_s;
    logic                        level_sel_s;
    logic                        sclk_fall;
    logic                        frame_start;
    logic                        frame_end;
    logic                        strobe_fall;
    logic [23:0]                 shift_reg;
    logic [4:0]                  bit_cnt_reg;
    logic                        strobe_held_reg;
    logic                        frame_ok;
    dac_update_pkg::cmd_t        cmd;
    dac_update_pkg::addr_t       addr;
    dac_update_pkg::code_t       code;
    dac_update_pkg::power_state_e pwr_reg;
    logic [15:0]                 por_cnt_reg;
    logic                        por_done;
    logic                        soft_reset;
    logic                        running;
    logic                        clear_all;
    dac_update_pkg::code_t       clear_code;
    logic [7:0]                  load_strobe_channel_mask_reg;
    logic [2:0]                  amplifier_gain_setup_reg;
    logic                        held_low;
    logic                        strobe_low;
    logic [NCH-1:0]              ch_sel;
    logic [NCH-1:0]              ch_write_input;
    logic [NCH-1:0]              ch_write_dac;
    logic [NCH-1:0]              ch_copy;

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 5'h1d;
            pin_sync_reg <= 5'h1d;
        end else begin
            pin_meta_reg <= {RESET_LEVEL_SELECT, DAC_RESET_N, LOAD_STROBE_N, SDI, SCLK};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign sclk_s       = pin_sync_reg[0];
    assign sdi_s        = pin_sync_reg[1];
    assign strobe_n_s   = pin_sync_reg[2];
    assign hw_reset_n_s = pin_sync_reg[3];
    assign level_sel_s  = pin_sync_reg[4];

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_reg <= 3'h7;
        end else begin
            pin_prev_reg <= {strobe_n_s, sync_n_s, sclk_s};
        end
    end

    // ----------------------------------------
    // frame sync synchroniser
    // ----------------------------------------
    logic sync_meta_reg;
    logic sync_sync_reg;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta_reg <= 1'b1;
            sync_sync_reg <= 1'b1;
        end else begin
            sync_meta_reg <= SYNC_N;
            sync_sync_reg <= sync_meta_reg;
        end
    end

    assign sync_n_s = sync_sync_reg;

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    assign sclk_fall   = pin_prev_reg[0] & ~sclk_s;
    assign frame_start = pin_prev_reg[1] & ~sync_n_s;
    assign frame_end   = ~pin_prev_reg[1] & sync_n_s;
    assign strobe_fall = pin_prev_reg[2] & ~strobe_n_s;
    assign strobe_low  = ~strobe_n_s;

    // ----------------------------------------
    // serial shifter
    // ----------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 24'h000000;
        end else if (!sync_n_s && sclk_fall) begin
            shift_reg <= {shift_reg[22:0], sdi_s};
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 5'h00;
        end else if (frame_start) begin
            bit_cnt_reg <= 5'h00;
        end else if (!sync_n_s && sclk_fall && bit_cnt_reg != 5'h1f) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // strobe seen low for the whole frame
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            strobe_held_reg <= 1'b0;
        end else if (frame_start) begin
            strobe_held_reg <= strobe_low;
        end else if (!sync_n_s && !strobe_low) begin
            strobe_held_reg <= 1'b0;
        end
    end

    assign frame_ok = frame_end && bit_cnt_reg == `FRAME_BITS; // see [RULE19]
    assign cmd      = shift_reg[`CMD_MSB:`CMD_LSB];
    assign addr     = shift_reg[`ADDR_MSB:`ADDR_LSB]; // see [RULE22]
    assign code     = shift_reg[`CODE_MSB:`CODE_LSB]; // see [RULE22]
    assign held_low = strobe_held_reg & strobe_low;

    // ----------------------------------------
    // command decode, complete frames only
    // ----------------------------------------
    logic                        do_write_input;
    logic                        do_update;
    logic                        do_write_update;
    logic                        do_load_mask;
    logic                        do_soft_reset;
    logic                        do_gain;

    assign do_write_input  = frame_ok && cmd == `CMD_WRITE_INPUT;
    assign do_update       = frame_ok && cmd == `CMD_UPDATE_DAC; // see [RULE8]
    assign do_write_update = frame_ok && cmd == `CMD_WRITE_UPDATE;
    assign do_load_mask    = frame_ok && cmd == `CMD_LOAD_MASK;
    assign do_soft_reset   = frame_ok && cmd == `CMD_SOFT_RESET;
    assign do_gain         = frame_ok && cmd == `CMD_GAIN_SETUP;

    // ----------------------------------------
    // power and reset sequencing
    // ----------------------------------------
    assign running    = pwr_reg == dac_update_pkg::PWR_RUN;
    assign soft_reset = running && do_soft_reset;
    assign por_done   = por_cnt_reg == 16'(`POR_CYCLES - 1);

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= dac_update_pkg::PWR_POR;
        end else begin
            unique case (pwr_reg)
                dac_update_pkg::PWR_POR: begin
                    // pins not looked at here, see [RULE14]
                    if (por_done) begin
                        pwr_reg <= dac_update_pkg::PWR_RUN;
                    end
                end
                dac_update_pkg::PWR_HW_RESET: begin
                    if (hw_reset_n_s) begin
                        pwr_reg <= dac_update_pkg::PWR_RUN;
                    end
                end
                dac_update_pkg::PWR_RUN: begin
                    if (soft_reset) begin
                        pwr_reg <= dac_update_pkg::PWR_POR; // see [RULE13]
                    end else if (!hw_reset_n_s) begin
                        pwr_reg <= dac_update_pkg::PWR_HW_RESET; // see [RULE10]
                    end
                end
                default: begin
                    pwr_reg <= dac_update_pkg::PWR_POR;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_reg <= 16'h0000;
        end else if (pwr_reg != dac_update_pkg::PWR_POR) begin
            por_cnt_reg <= 16'h0000;
        end else if (!por_done) begin
            por_cnt_reg <= por_cnt_reg + 16'h0001;
        end
    end

    // clear in power-on or while pin seen low, see [RULE12]
    // stops once release is seen, so a level change cannot leak in
    assign clear_all  = pwr_reg == dac_update_pkg::PWR_POR
        || (pwr_reg == dac_update_pkg::PWR_HW_RESET && !hw_reset_n_s);
    // see [RULE10] [RULE15]
    assign clear_code = level_sel_s ? `MID_SCALE_CODE : `ZERO_SCALE_CODE;

    // ----------------------------------------
    // strobe mask register
    // ----------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            load_strobe_channel_mask_reg <= `MASK_RESET; // see [RULE4]
        end else if (pwr_reg == dac_update_pkg::PWR_POR) begin
            load_strobe_channel_mask_reg <= `MASK_RESET; // see [RULE13]
        end else if (do_load_mask) begin
            // address field not decoded, see [RULE3]
            load_strobe_channel_mask_reg <= shift_reg[`MASK_MSB:0];
        end
    end

    // ----------------------------------------
    // gain setup register
    // ----------------------------------------
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            amplifier_gain_setup_reg <= `GAIN_RESET;
        end else if (pwr_reg == dac_update_pkg::PWR_POR) begin
            amplifier_gain_setup_reg <= `GAIN_RESET;
        end else if (do_gain) begin
            // bits 19 to 3 dropped, see [RULE18]
            amplifier_gain_setup_reg <= shift_reg[`GAIN_FIELD_MSB:0];
        end
    end

    // ----------------------------------------
    // channels
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            dac_update_pkg::code_t dac_code;

            assign ch_sel[i] = addr == 4'(i); // see [RULE22]

            // see [RULE9] [RULE2]
            assign ch_write_input[i] = running && ch_sel[i]
                && (do_write_input || do_write_update);

            // see [RULE1] [RULE7] [RULE20] [RULE5] [RULE9]
            assign ch_write_dac[i] = running && ch_sel[i]
                && (do_write_update
                    || (do_write_input
                        && (held_low
                            || (strobe_low && !load_strobe_channel_mask_reg[i]))));

            // see [RULE6] [RULE2] [RULE5] [RULE8] [RULE21]
            assign ch_copy[i] = running
                && ((do_update && ch_sel[i])
                    || (strobe_fall && !load_strobe_channel_mask_reg[i]));

            // holds value between loads, see [RULE11] [RULE16]
            dac_channel_cell u_cell (
                .clk         (CLK),
                .rst_n       (rst_n),
                .clear       (clear_all),
                .clear_code  (clear_code),
                .write_input (ch_write_input[i]),
                .write_dac   (ch_write_dac[i]),
                .copy_input  (ch_copy[i]),
                .data        (code),
                .input_code  (),
                .dac_code    (dac_code)
            );

            assign DAC_CODES[16*i +: 16] = dac_code;
        end
    endgenerate

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign STROBE_MASK = load_strobe_channel_mask_reg;
    assign GAIN_SEL    = amplifier_gain_setup_reg[`GAIN_BIT]; // see [RULE17]
    assign POR_BUSY    = pwr_reg == dac_update_pkg::PWR_POR;

endmodule

// ===== dv/dac_host_model.sv
`timescale 1ns/10ps
module dac_host_model (
    output logic SCLK,
    output logic SYNC_N,
    output logic SDI
);
    initial begin
        SCLK = 1'b1;
        SYNC_N = 1'b1;
        SDI = 1'b0;
    end
    // ----------------
    // one framed write
    // ----------------
    task automatic send(input logic [23:0] frame, input int nbits);
        #2;
        SYNC_N = 1'b0;
        #62.5;
        for (int i = 0; i < nbits; i++) begin
            SDI = frame[23 - i];
            #62.5;
            SCLK = 1'b0;
            #62.5;
            SCLK = 1'b1;
        end
        #62.5;
        SYNC_N = 1'b1;
        SDI = ~SDI;
        #250;
    endtask
endmodule

// ===== dv/dac_update_properties.sv
`timescale 1ns/10ps
`include "dac_update_defines.svh"
module dac_update_properties (
    input wire logic         CLK,
    input wire logic         RESETN,
    input wire logic         SCLK,
    input wire logic         SYNC_N,
    input wire logic         SDI,
    input wire logic         LOAD_STROBE_N,
    input wire logic         DAC_RESET_N,
    input wire logic         RESET_LEVEL_SELECT,
    input wire logic [127:0] DAC_CODES,
    input wire logic [7:0]   STROBE_MASK,
    input wire logic         GAIN_SEL,
    input wire logic         POR_BUSY
);
    // ----------------
    // helpers
    // ----------------
    logic [7:0]   por_cnt_reg;
    logic [127:0] clear_codes;
    assign clear_codes = RESET_LEVEL_SELECT ? {8{`MID_SCALE_CODE}} : {8{`ZERO_SCALE_CODE}};
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            por_cnt_reg <= 8'h00;
        end else if (POR_BUSY && por_cnt_reg != 8'hff) begin
            por_cnt_reg <= por_cnt_reg + 8'h01;
        end else if (!POR_BUSY) begin
            por_cnt_reg <= 8'h00;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence frame_ended;
        $past(SYNC_N, 3);
    endsequence
    // ----------------
    // assertions
    // ----------------
    por_length_a: assert property ($fell(POR_BUSY) |->
        por_cnt_reg >= 8'h30 && por_cnt_reg <= 8'h38) else $error("power-on length wrong");
    mask_por_a: assert property (POR_BUSY && $past(POR_BUSY) |->
        STROBE_MASK == 8'h00) else $error("mask not cleared in power-on");
    gain_por_a: assert property (POR_BUSY && $past(POR_BUSY) |-> !GAIN_SEL)
        else $error("gain not cleared in power-on");
    por_codes_a: assert property (POR_BUSY && por_cnt_reg >= 8'h06 &&
        $past(RESET_LEVEL_SELECT, 6) == RESET_LEVEL_SELECT |-> DAC_CODES == clear_codes)
        else $error("power-on code wrong");
    mask_change_a: assert property ($changed(STROBE_MASK) |->
        POR_BUSY || $past(SYNC_N, 3)) else $error("mask changed outside frame end");
    gain_change_a: assert property ($changed(GAIN_SEL) && !POR_BUSY |->
        frame_ended) else $error("gain changed outside frame end");
    frame_quiet_a: assert property (
        (!SYNC_N && LOAD_STROBE_N && DAC_RESET_N && !POR_BUSY)[*6] |-> $stable(DAC_CODES))
        else $error("codes moved inside frame");
    hw_clear_a: assert property (
        (!DAC_RESET_N && !POR_BUSY && $stable(RESET_LEVEL_SELECT))[*6]
        |-> DAC_CODES == clear_codes)
        else $error("pin reset code wrong");
    cover property ($fell(POR_BUSY));
    cover property ($changed(STROBE_MASK) && !POR_BUSY);
    cover property ($rose(GAIN_SEL));
endmodule
bind dac_update_reset_gain_control dac_update_properties chk_u (.CLK(CLK), .RESETN(RESETN),
    .SCLK(SCLK), .SYNC_N(SYNC_N), .SDI(SDI), .LOAD_STROBE_N(LOAD_STROBE_N),
    .DAC_RESET_N(DAC_RESET_N), .RESET_LEVEL_SELECT(RESET_LEVEL_SELECT),
    .DAC_CODES(DAC_CODES), .STROBE_MASK(STROBE_MASK), .GAIN_SEL(GAIN_SEL), .POR_BUSY(POR_BUSY));

// ===== dv/dac_update_reset_gain_control_tb_top.sv
`timescale 1ns/10ps
module dac_update_reset_gain_control_tb_top;
    logic         CLK, RESETN, LOAD_STROBE_N, DAC_RESET_N, RESET_LEVEL_SELECT;
    wire logic    SCLK, SYNC_N, SDI;
    logic [127:0] DAC_CODES;
    logic [7:0]   STROBE_MASK;
    logic         GAIN_SEL, POR_BUSY;
    int           err_total = 0;
    int           n_compared = 0;
    int           cyc = 0;
    dac_host_model host_u (.SCLK(SCLK), .SYNC_N(SYNC_N), .SDI(SDI));
    dac_update_reset_gain_control dut_u (.CLK(CLK), .RESETN(RESETN), .SCLK(SCLK),
        .SYNC_N(SYNC_N), .SDI(SDI), .LOAD_STROBE_N(LOAD_STROBE_N), .DAC_RESET_N(DAC_RESET_N),
        .RESET_LEVEL_SELECT(RESET_LEVEL_SELECT), .DAC_CODES(DAC_CODES),
        .STROBE_MASK(STROBE_MASK), .GAIN_SEL(GAIN_SEL), .POR_BUSY(POR_BUSY));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // ----------------
    // shared tasks
    // ----------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] ch(input int n);
        return DAC_CODES[16*n +: 16];
    endfunction
    task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
        host_u.send({c, a, d}, 24);
        repeat (10) @(posedge CLK);
    endtask
    task automatic pulse_strobe;
        @(posedge CLK);
        LOAD_STROBE_N <= 1'b0;
        repeat (4) @(posedge CLK);
        LOAD_STROBE_N <= 1'b1;
        repeat (8) @(posedge CLK);
    endtask
    task automatic wait_por;
        for (int i = 0; i < 300 && POR_BUSY !== 1'b0; i++) @(posedge CLK);
        check("por_busy", {15'h0000, POR_BUSY}, 16'h0000);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_power_up;
        wait_por;
        for (int n = 0; n < 8; n++) check("power_code", ch(n), 16'h8000);
        check("mask", {8'h00, STROBE_MASK}, 16'h0000);
        check("gain", {15'h0000, GAIN_SEL}, 16'h0000);
        frame(4'h1, 4'h0, 16'h1234);
        check("held_code", ch(0), 16'h8000);
        $display("test power_up done");
    endtask
    task automatic t_deferred;
        frame(4'h1, 4'h3, 16'h3333);
        check("deferred_ch3", ch(3), 16'h8000);
        pulse_strobe;
        check("strobe_ch3", ch(3), 16'h3333);
        check("strobe_ch0", ch(0), 16'h1234);
        $display("test deferred done");
    endtask
    task automatic t_mask;
        frame(4'h5, 4'ha, 16'h0008);
        check("mask", {8'h00, STROBE_MASK}, 16'h0008);
        frame(4'h1, 4'h3, 16'h4444);
        frame(4'h1, 4'h2, 16'h2222);
        pulse_strobe;
        check("unmasked_ch2", ch(2), 16'h2222);
        check("masked_ch3", ch(3), 16'h3333);
        frame(4'h2, 4'h3, 16'h0000);
        check("update_ch3", ch(3), 16'h4444);
        frame(4'h3, 4'h3, 16'h5555);
        check("write_update_ch3", ch(3), 16'h5555);
        $display("test mask done");
    endtask
    task automatic t_strobe_low;
        LOAD_STROBE_N <= 1'b0;
        repeat (8) @(posedge CLK);
        frame(4'h1, 4'h1, 16'h1111);
        check("low_ch1", ch(1), 16'h1111);
        frame(4'h5, 4'h0, 16'h00ff);
        frame(4'h1, 4'h3, 16'h7777);
        check("low_masked_ch3", ch(3), 16'h7777);
        LOAD_STROBE_N <= 1'b1;
        frame(4'h5, 4'h0, 16'h0000);
        $display("test strobe_low done");
    endtask
    task automatic t_gain;
        frame(4'h7, 4'h0, 16'h0004);
        check("gain_two", {15'h0000, GAIN_SEL}, 16'h0001);
        host_u.send({4'h7, 4'h0, 16'h0000}, 23);
        repeat (10) @(posedge CLK);
        check("short_frame", {15'h0000, GAIN_SEL}, 16'h0001);
        $display("test gain done");
    endtask
    task automatic t_hw_reset;
        DAC_RESET_N <= 1'b0;
        RESET_LEVEL_SELECT <= 1'b0;
        repeat (10) @(posedge CLK);
        for (int n = 0; n < 8; n++) check("clear_code", ch(n), 16'h0000);
        frame(4'h3, 4'h2, 16'h9999);
        pulse_strobe;
        check("blocked_ch2", ch(2), 16'h0000);
        DAC_RESET_N <= 1'b1;
        RESET_LEVEL_SELECT <= 1'b1;
        repeat (10) @(posedge CLK);
        check("cleared_hold", ch(2), 16'h0000);
        frame(4'h3, 4'h2, 16'h9999);
        check("rewrite_ch2", ch(2), 16'h9999);
        $display("test hw_reset done");
    endtask
    task automatic t_soft;
        frame(4'h5, 4'h0, 16'h0003);
        host_u.send({4'h6, 4'h0, 16'h0000}, 24);
        repeat (6) @(posedge CLK);
        check("soft_busy", {15'h0000, POR_BUSY}, 16'h0001);
        pulse_strobe;
        wait_por;
        for (int n = 0; n < 8; n++) check("soft_code", ch(n), 16'h8000);
        check("soft_mask", {8'h00, STROBE_MASK}, 16'h0000);
        check("soft_gain", {15'h0000, GAIN_SEL}, 16'h0000);
        $display("test soft_reset done");
    endtask
    // ----------------
    // main sequence
    // ----------------
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            finish_test;
        end
    end
    initial begin
        RESETN = 1'b0;
        LOAD_STROBE_N = 1'b1;
        DAC_RESET_N = 1'b1;
        RESET_LEVEL_SELECT = 1'b1;
        repeat (16) @(posedge CLK);
        RESETN <= 1'b1;
        t_power_up;
        t_deferred;
        t_mask;
        t_strobe_low;
        t_gain;
        t_hw_reset;
        t_soft;
        finish_test;
    end
endmodule
